/* File: core/sdl_serial_dac.v */
// Serial frame receiver and double-buffered DAC register bank
// Summary of operation
// - Low frame sync enables the input shift register for serial data.
// - One 16-bit word per frame, bits taken on serial clock falling edges.
// - Low load input copies all data registers to DAC registers together.
// - Load low at sixteenth falling edge or held low updates automatically.
// - Clear low resets all main and sub DAC values to bias level.
// - Low power-down input puts the device into low-power mode.
// - Channel control bit selects the external reference for that DAC.
`timescale 1ns/1ps
`include "sdl_consts.vh"
module sdl_serial_dac #(
  parameter NCH = 8
) (
  input wire sys_clk_i, // 100 MHz system clock
  input wire rst_i, // Async reset, active high
  input wire frame_sync_n_i, // Frame sync pin, active low
  input wire serial_clock_in_i, // Serial clock pin
  input wire serial_data_in_i, // Serial data pin
  input wire load_outputs_n_i, // Load strobe pin, active low
  input wire async_clear_n_i, // Clear pin, active low
  input wire power_down_n_i, // Power-down pin, active low
  output reg [NCH*`SDL_DATA_BITS-1:0] dac_value_o, // Main DAC codes
  output reg [NCH-1:0] ext_ref_sel_o, // Channel uses external reference
  output reg [NCH-1:0] sub_clear_o, // Channel sub DAC held cleared
  output reg low_power_o, // Device in low-power mode
  output reg word_done_o // Pulse when a word was accepted
);
  localparam DW = `SDL_DATA_BITS;
  // One-hot frame receiver states
  localparam ST_IDLE = 3'h1;
  localparam ST_SHIFT = 3'h2;
  localparam ST_FULL = 3'h4;
  wire [5:0] pins_s;
  wire fs_n_s;
  wire sck_s;
  wire sdi_s;
  wire ld_n_s;
  wire clr_n_s;
  wire pd_n_s;
  reg sck_d_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`SDL_WORD_BITS-1:0] shift_r;
  reg [`SDL_CNT_BITS-1:0] cnt_r;
  reg [NCH*DW-1:0] data_r;
  reg [`SDL_CTRL_BITS-1:0] sys_ctrl_r;
  reg [NCH-1:0] refsel_r;
  reg [NCH-1:0] chclr_r;
  reg full_r;
  reg auto_r;
  reg auto_d_r;
  wire fall_s;
  wire take_s;
  wire last_s;
  wire [`SDL_WORD_BITS-1:0] word_s;
  wire [`SDL_CH_BITS-1:0] ch_s;
  wire ctrl_s;
  wire sys_s;
  wire [NCH-1:0] ch_hit_s;
  wire [NCH-1:0] wr_data_s;
  wire [NCH-1:0] wr_ctrl_s;
  wire load_s;
  integer i;
  genvar g;

  function [NCH-1:0] ch_dec;
    input [`SDL_CH_BITS-1:0] ch;
    integer k;
    begin
      ch_dec = {NCH{1'b0}};
      for (k = 0; k < NCH; k = k + 1) begin
        if (ch == k[`SDL_CH_BITS-1:0]) begin
          ch_dec[k] = 1'b1;
        end
      end
    end
  endfunction

  // Every pin, clear included, passes two flops before logic reads it
  sdl_sync #(.W(6), .RST_VAL(6'h3F)) u_sync (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i({frame_sync_n_i, serial_clock_in_i, serial_data_in_i,
          load_outputs_n_i, async_clear_n_i, power_down_n_i}),
    .q_o(pins_s)
  );
  assign fs_n_s = pins_s[5];
  assign sck_s = pins_s[4];
  assign sdi_s = pins_s[3];
  assign ld_n_s = pins_s[2];
  assign clr_n_s = pins_s[1];
  assign pd_n_s = pins_s[0];

  assign fall_s = sck_d_r & ~sck_s;
  // Bits past the sixteenth are ignored until frame sync rises again
  assign take_s = fall_s & ~fs_n_s & (state_r != ST_FULL);
  assign last_s = (cnt_r == `SDL_LAST_IDX);
  assign word_s = {shift_r[`SDL_WORD_BITS-2:0], sdi_s};
  // Decode reads the completed word as it stands in the shift register
  assign ch_s = shift_r[`SDL_ADDR_LSB+`SDL_CH_BITS-1:`SDL_ADDR_LSB];
  assign ctrl_s = shift_r[`SDL_CTRL_BIT];
  assign sys_s = (ch_s == `SDL_SYS_CH) && (NCH < 8 || ctrl_s);
  assign ch_hit_s = ch_dec(ch_s);
  assign load_s = ~ld_n_s | auto_d_r;

  // Per-channel write strobes for data and channel control words
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_wr
      assign wr_data_s[g] = full_r & ~sys_s & ~ctrl_s & ch_hit_s[g];
      assign wr_ctrl_s[g] = full_r & ~sys_s & ctrl_s & ch_hit_s[g];
    end
  endgenerate

  // Frame receiver state: idle, shifting, word complete
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (!fs_n_s) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (fs_n_s) begin
          state_nxt = ST_IDLE;
        end else if (take_s && last_s) begin
          state_nxt = ST_FULL;
        end
      end
      ST_FULL: begin
        if (fs_n_s) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Serial shift: enabled while frame sync low, one word per frame
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_d_r <= 1'b1;
      state_r <= ST_IDLE;
      shift_r <= {`SDL_WORD_BITS{1'b0}};
      cnt_r <= {`SDL_CNT_BITS{1'b0}};
      full_r <= 1'b0;
      auto_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
      state_r <= state_nxt;
      full_r <= 1'b0;
      auto_r <= 1'b0;
      if (fs_n_s) begin
        cnt_r <= {`SDL_CNT_BITS{1'b0}};
      end else if (take_s) begin
        shift_r <= word_s;
        cnt_r <= cnt_r + 5'h01;
        if (last_s) begin
          full_r <= 1'b1;
          auto_r <= ~ld_n_s;
        end
      end
    end
  end

  // Word decode into data and control registers
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_r <= {NCH*DW{1'b0}};
      sys_ctrl_r <= `SDL_CTRL_RST;
      refsel_r <= {NCH{1'b0}};
      // Sub DACs leave reset cleared, as the output register does
      chclr_r <= {NCH{1'b1}};
      auto_d_r <= 1'b0;
      word_done_o <= 1'b0;
    end else begin
      word_done_o <= full_r;
      // Automatic load waits a cycle so the new code is already stored
      auto_d_r <= auto_r;
      if (full_r && sys_s && ctrl_s) begin
        sys_ctrl_r <= shift_r[`SDL_CTRL_BITS-1:0];
      end
      for (i = 0; i < NCH; i = i + 1) begin
        if (wr_ctrl_s[i]) begin
          refsel_r[i] <= shift_r[`SDL_CH_REFSEL_BIT];
          chclr_r[i] <= shift_r[`SDL_CH_CLR_BIT];
        end
        if (wr_data_s[i]) begin
          data_r[i*DW +: DW] <= shift_r[`SDL_DATA_MSB:0];
        end
      end
    end
  end

  // DAC registers: clear pin overrides, load low or auto load copies all
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dac_value_o <= {NCH*DW{1'b0}};
      ext_ref_sel_o <= {NCH{1'b0}};
      sub_clear_o <= {NCH{1'b1}};
      low_power_o <= 1'b0;
    end else begin
      ext_ref_sel_o <= refsel_r;
      low_power_o <= ~pd_n_s | sys_ctrl_r[`SDL_SYS_PD_BIT];
      if (!clr_n_s) begin
        dac_value_o <= {NCH*DW{1'b0}};
        sub_clear_o <= {NCH{1'b1}};
      end else begin
        sub_clear_o <= chclr_r;
        if (load_s) begin
          dac_value_o <= data_r;
        end
      end
    end
  end
endmodule // sdl_serial_dac

/* File: include/sdl_consts.vh */
// Constants for the serial DAC load interface
`ifndef SDL_CONSTS_VH
`define SDL_CONSTS_VH
`define SDL_WORD_BITS 16
`define SDL_DATA_BITS 10
`define SDL_CNT_BITS 5
`define SDL_ADDR_MSB 15
`define SDL_ADDR_LSB 12
`define SDL_DATA_MSB 9
`define SDL_CH_BITS 3
`define SDL_CTRL_BIT 15
`define SDL_SYS_CH 3'h7
`define SDL_SYS_PD_BIT 0
`define SDL_CH_REFSEL_BIT 0
`define SDL_CH_CLR_BIT 1
`define SDL_DATA_RST 10'h000
`define SDL_CTRL_RST 8'h00
`define SDL_CTRL_BITS 8
`define SDL_LAST_IDX 5'h0F
`endif

/* File: core/sdl_sync.v */
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sdl_sync #(
  parameter W = 5,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire clk_i, // Sampling clock
  input wire rst_i, // Async reset, active high
  input wire [W-1:0] d_i, // Asynchronous inputs
  output wire [W-1:0] q_o // Synchronised outputs
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end
  assign q_o = sync_r;
endmodule // sdl_sync

/* File: test/sdl_host_model.sv */
// Host side model driving serial frames into the block
`timescale 1ns/1ps
module sdl_host_model (
  output logic fs_n_o, // Frame sync, active low
  output logic sck_o, // Serial clock, still high between frames
  output logic sd_o // Serial data, MSB first
);
  initial {fs_n_o, sck_o, sd_o} = 3'h6;
  task automatic send(logic [15:0] w, int nb);
    fs_n_o = 1'h0;
    for (int i = 15; i > 15 - nb; i--) begin
      sd_o = w[i];
      #40 sck_o = 1'h0;
      #40 sck_o = 1'h1;
    end
    #40 fs_n_o = 1'h1;
    sd_o = ~sd_o;
  endtask
endmodule // sdl_host_model

/* File: test/sdl_serial_dac_asserts.sv */
// Port assertions for the serial DAC load block
`timescale 1ns/1ps
module sdl_serial_dac_asserts #(parameter NCH = 8) (
  input wire sys_clk_i, rst_i, frame_sync_n_i, load_outputs_n_i,
  input wire async_clear_n_i, power_down_n_i, low_power_o, word_done_o,
  input wire [NCH*10-1:0] dac_value_o,
  input wire [NCH-1:0] ext_ref_sel_o, sub_clear_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_done_pulse: assert property (
    word_done_o |=> (!word_done_o)[*8]) else $error("pulse");
  a_done_frame: assert property (
    word_done_o |-> !$past(frame_sync_n_i, 6)) else $error("frame");
  a_clear_dac: assert property (
    (!async_clear_n_i)[*3] |=> dac_value_o == '0) else $error("clear");
  a_clear_sub: assert property (
    (!async_clear_n_i)[*3] |=> &sub_clear_o) else $error("sub");
  a_pd_low: assert property (
    (!power_down_n_i)[*4] |-> low_power_o) else $error("pd");
  a_lp_cause: assert property ($rose(low_power_o) |->
    word_done_o || $past(word_done_o) || !$past(power_down_n_i, 2))
    else $error("lp");
  a_load_idle: assert property (
    (load_outputs_n_i && async_clear_n_i)[*7] |=> $stable(dac_value_o))
    else $error("idle");
  a_ctl_cause: assert property (
    $changed({ext_ref_sel_o, sub_clear_o}) |-> $past(word_done_o) ||
    !$past(async_clear_n_i, 3) || !$past(async_clear_n_i, 4))
    else $error("ctl");
  c_word: cover property (word_done_o);
  c_clear: cover property (!async_clear_n_i ##1 &sub_clear_o);
  c_lp: cover property ($rose(low_power_o));
endmodule // sdl_serial_dac_asserts
bind sdl_serial_dac sdl_serial_dac_asserts #(.NCH(NCH)) i_sva (.*);

/* File: test/sdl_serial_dac_bench.sv */
// Self-checking bench for the serial DAC load block
`timescale 1ns/1ps
module sdl_serial_dac_bench;
  logic sys_clk_i = 1'h0, rst_i = 1'h1, ld_n = 1'h1, clr_n = 1'h1;
  logic pd_n = 1'h1, spd = 1'h0, fs_n, sck, sd, lp, done;
  logic [79:0] dac, pend = '0, edac = '0;
  logic [7:0] xref, sclr, exr = '0, esc = 8'hFF;
  int errors = 0, checked = 0, cyc = 0, ndone = 0, nword = 0;
  initial forever #5 sys_clk_i = ~sys_clk_i;
  sdl_host_model i_host (.fs_n_o(fs_n), .sck_o(sck), .sd_o(sd));
  sdl_serial_dac #(.NCH(8)) i_dut (.sys_clk_i, .rst_i,
    .frame_sync_n_i(fs_n), .serial_clock_in_i(sck), .serial_data_in_i(sd),
    .load_outputs_n_i(ld_n), .async_clear_n_i(clr_n),
    .power_down_n_i(pd_n), .dac_value_o(dac), .ext_ref_sel_o(xref),
    .sub_clear_o(sclr), .low_power_o(lp), .word_done_o(done));
  task summarize;
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(logic [79:0] g, e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wt(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Short frames are aborted and must leave every data and control register alone
  task word(logic [15:0] w, int nb = 16);
    int c;
    c = w[14:12];
    i_host.send(w, nb);
    wt(12);
    if (nb == 16 && !w[15]) pend[c*10+:10] = w[9:0];
    if (nb == 16 && w[15] && c == 7) spd = w[0];
    if (nb == 16 && w[15] && c < 7) {esc[c], exr[c]} = w[1:0];
    if (!ld_n) edac = pend;
    cmp(dac, edac);
    cmp({xref, sclr, lp}, {exr, esc, spd | ~pd_n});
    if (nb == 16) nword++;
    cmp(ndone, nword);
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (done === 1'h1) ndone++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    void'($urandom(37));
    wt(16);
    rst_i = 1'h0;
    wt(3);
    for (int c = 0; c < 16; c++) word({c[3], c[2:0], 12'($urandom)});
    ld_n = 1'h0;
    edac = pend;
    wt(8);
    cmp(dac, edac);
    word({4'h3, 12'($urandom)});
    word(16'h5155, 8);
    pd_n = 1'h0;
    wt(6);
    cmp(lp, 1'h1);
    pd_n = 1'h1;
    word(16'hF001);
    word(16'hF000);
    clr_n = 1'h0;
    wt(4);
    cmp(dac, '0);
    cmp(sclr, 8'hFF);
    summarize();
  end
endmodule // sdl_serial_dac_bench
